//--- hw/hbc_defines.vh
`ifndef HBC_DEFINES_VH
`define HBC_DEFINES_VH
// ==========================================================
// Register byte addresses (printed offsets are register indices)
`define HBC_IDX_OUTSEL      4'h1
`define HBC_IDX_STSCTL      4'h3
`define HBC_ADDR_OUTSEL     6'h04
`define HBC_ADDR_STSCTL     6'h0C
`define HBC_ADDR_SYSTEM_CONTROL_REG     6'h20
`define HBC_ADDR_IRQFLAG    6'h24
`define HBC_ADDR_IRQMASK    6'h28
`define HBC_ADDR_MUXCTL     6'h2C
`define HBC_ADDR_FAULTIN    6'h30
// ==========================================================
// Field positions
`define HBC_STS_RECIRC      0
`define HBC_STS_OCF_LSB     4
`define HBC_SYS_POWER_STAGE_ENABLE        0
`define HBC_SYS_VIS         1
`define HBC_SYS_SHDN_LSB    2
`define HBC_IRQ_OT          0
`define HBC_IRQ_UV          1
`define HBC_IRQ_OV          2
`define HBC_MUX_GAIN        0
`define HBC_MUX_SEL_LSB     4
// ==========================================================
// Reset values
`define HBC_RST_BYTE        8'h00
`define HBC_RST_SHDN        2'h0
`endif

//--- hw/hbc_bridge_ctrl.v
// Behaviour
// - Outputs stay off unless the global power stage enable is set.
// - Select pair decodes off, low on, high on, high PWM.
// - High and low never on together; both bits mean PWM.
// - Break-before-make: opposite gate must read off before turn-on.
// - PWM mode: high switch follows the PWM input level.
// - Recirculation bit on: low switch on while PWM high switch off.
// - Reset clears all bridge select bits.
// - Reset clears the recirculation mode bit.
// - Over-current on either switch turns both switches of its bridge off and sets bridge flag.
// - Writing one clears bridge over-current flag; zero ignored; reset clears.
// - First threshold sets over-temp flag; interrupt only when masked in.
// - Over-temp shutdown select turns stages off while flag set.
// - Over-temp flag clears by one or reset, not while hot.
// - With first shutdown off, second threshold kills all stages.
// - Voltage fault flag with inhibit clear disables bridge outputs.
// - Voltage flags clear by one or reset, not while fault present.
// - Low-side sense routed to mux; gain bit one is low resolution.
`include "hbc_defines.vh"
module hbc_bridge_ctrl #(
  parameter NUM_BRIDGES = 4
) (
  input  wire                   core_clk_i,
  input  wire                   rst_n_i,
  input  wire [5:0]             avs_address_i,
  input  wire                   avs_read_i,
  input  wire                   avs_write_i,
  input  wire [31:0]            avs_writedata_i,
  output wire [31:0]            avs_readdata_o,
  output wire                   avs_waitrequest_o,
  input  wire                   pwm_i,
  input  wire [NUM_BRIDGES-1:0] hs_oc_i,
  input  wire [NUM_BRIDGES-1:0] ls_oc_i,
  input  wire [NUM_BRIDGES-1:0] hs_gate_off_i,
  input  wire [NUM_BRIDGES-1:0] ls_gate_off_i,
  input  wire                   first_temp_threshold_i,
  input  wire                   second_temp_threshold_i,
  input  wire                   undervoltage_i,
  input  wire                   overvoltage_i,
  output wire [NUM_BRIDGES-1:0] hs_on_o,
  output wire [NUM_BRIDGES-1:0] ls_on_o,
  output wire                   all_stages_off_o,
  output wire                   sense_gain_select_o,
  output wire [3:0]             mux_select_o,
  output wire                   irq_o
);

  // ==========================================================
  // Register state
  reg [7:0]             outsel_reg;
  reg                   recirc_reg;
  reg [NUM_BRIDGES-1:0] ocf_reg;
  reg                   power_stage_enable_reg;
  reg                   vis_reg;
  reg [1:0]             shdn_sel_reg;
  reg [2:0]             irq_flag_reg;
  reg [2:0]             irq_mask_reg;
  reg                   gain_reg;
  reg [3:0]             mux_sel_reg;
  reg [31:0]            rdata_reg;
  reg                   wait_reg;
  reg [NUM_BRIDGES-1:0] hs_on_reg;
  reg [NUM_BRIDGES-1:0] ls_on_reg;
  reg                   kill_reg;
  reg                   irq_reg;

  // Writes land on the edge that completes the access, with
  // waitrequest low; reads are captured one edge earlier so the
  // data already stand when the master samples them
  wire wr_cyc = avs_write_i & ~wait_reg;
  wire rd_cyc = avs_read_i & wait_reg;

  // Write-one-to-clear test on a bus bit
  function w1c;
    input [31:0] data;
    input integer pos;
    begin
      w1c = data[pos];
    end
  endfunction

  // High switch request: plain on, or PWM mode following the input
  function dec_high;
    input hi;
    input lo;
    input pw;
    begin
      dec_high = hi & (~lo | pw);
    end
  endfunction

  // Low switch request: plain on, or PWM gap with recirculation on
  function dec_low;
    input hi;
    input lo;
    input pw;
    input rc;
    begin
      dec_low = lo & (~hi | (rc & ~pw));
    end
  endfunction

  wire wr_sts = wr_cyc & (avs_address_i == `HBC_ADDR_STSCTL);
  wire wr_irq = wr_cyc & (avs_address_i == `HBC_ADDR_IRQFLAG);

  // ==========================================================
  // Bus handshake: one wait cycle, then accept
  // Idle high, so every access sees exactly one wait state;
  // low for a single cycle so a held request is never taken twice
  // and back-to-back accesses each pay their own wait
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wait_reg <= 1'b1;
    else if ((avs_read_i | avs_write_i) & wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  // ==========================================================
  // Software registers: output select
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      outsel_reg <= `HBC_RST_BYTE;
    else if (wr_cyc && (avs_address_i == `HBC_ADDR_OUTSEL))
      outsel_reg <= avs_writedata_i[7:0];
  end

  // Recirculation mode bit
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      recirc_reg <= 1'b0;
    else if (wr_sts)
      recirc_reg <= avs_writedata_i[`HBC_STS_RECIRC];
  end

  // System control: enable, inhibit, over-temp shutdown select
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      power_stage_enable_reg     <= 1'b0;
      vis_reg      <= 1'b0;
      shdn_sel_reg <= `HBC_RST_SHDN;
    end
    else if (wr_cyc && (avs_address_i == `HBC_ADDR_SYSTEM_CONTROL_REG))
    begin
      power_stage_enable_reg     <= avs_writedata_i[`HBC_SYS_POWER_STAGE_ENABLE];
      vis_reg      <= avs_writedata_i[`HBC_SYS_VIS];
      shdn_sel_reg <= avs_writedata_i[`HBC_SYS_SHDN_LSB+1:`HBC_SYS_SHDN_LSB];
    end
  end

  // Interrupt mask, same layout as the flags
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_mask_reg <= 3'h0;
    else if (wr_cyc && (avs_address_i == `HBC_ADDR_IRQMASK))
      irq_mask_reg <= avs_writedata_i[2:0];
  end

  // Mux control: sense gain and source select
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gain_reg    <= 1'b0;
      mux_sel_reg <= 4'h0;
    end
    else if (wr_cyc && (avs_address_i == `HBC_ADDR_MUXCTL))
    begin
      gain_reg    <= avs_writedata_i[`HBC_MUX_GAIN];
      mux_sel_reg <= avs_writedata_i[`HBC_MUX_SEL_LSB+3:`HBC_MUX_SEL_LSB];
    end
  end

  // ==========================================================
  // Sticky fault flags, set wins over clear
  integer i;
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ocf_reg      <= {NUM_BRIDGES{1'b0}};
      irq_flag_reg <= 3'h0;
    end
    else
    begin
      for (i = 0; i < NUM_BRIDGES; i = i + 1)
      begin
        if (hs_oc_i[i] | ls_oc_i[i])
          ocf_reg[i] <= 1'b1;
        else if (wr_sts & w1c(avs_writedata_i, `HBC_STS_OCF_LSB + i))
          ocf_reg[i] <= 1'b0;
      end
      if (first_temp_threshold_i)
        irq_flag_reg[`HBC_IRQ_OT] <= 1'b1;
      else if (wr_irq & w1c(avs_writedata_i, `HBC_IRQ_OT))
        irq_flag_reg[`HBC_IRQ_OT] <= 1'b0;
      if (undervoltage_i)
        irq_flag_reg[`HBC_IRQ_UV] <= 1'b1;
      else if (wr_irq & w1c(avs_writedata_i, `HBC_IRQ_UV))
        irq_flag_reg[`HBC_IRQ_UV] <= 1'b0;
      if (overvoltage_i)
        irq_flag_reg[`HBC_IRQ_OV] <= 1'b1;
      else if (wr_irq & w1c(avs_writedata_i, `HBC_IRQ_OV))
        irq_flag_reg[`HBC_IRQ_OV] <= 1'b0;
    end
  end

  // ==========================================================
  // Shutdown conditions
  wire ot_shdn_en = |shdn_sel_reg;
  wire ot_kill    = ot_shdn_en & irq_flag_reg[`HBC_IRQ_OT];
  wire hard_kill  = ~ot_shdn_en & second_temp_threshold_i;
  wire v_kill     = ~vis_reg & (irq_flag_reg[`HBC_IRQ_UV] | irq_flag_reg[`HBC_IRQ_OV]);

  // ==========================================================
  // Per-bridge forced-off vector; a live over-current blanks the
  // whole bridge at once, before its flag has latched
  wire                   stage_kill = ot_kill | hard_kill | v_kill;
  wire [NUM_BRIDGES-1:0] bridge_off = ocf_reg | hs_oc_i | ls_oc_i |
                                      {NUM_BRIDGES{~power_stage_enable_reg | stage_kill}};

  // ==========================================================
  // Bridge decode and gating
  reg [NUM_BRIDGES-1:0] hs_next;
  reg [NUM_BRIDGES-1:0] ls_next;
  reg                   sel_h;
  reg                   sel_l;
  integer               b;
  always @*
  begin
    hs_next = {NUM_BRIDGES{1'b0}};
    ls_next = {NUM_BRIDGES{1'b0}};
    sel_h   = 1'b0;
    sel_l   = 1'b0;
    for (b = 0; b < NUM_BRIDGES; b = b + 1)
    begin
      sel_l = outsel_reg[2*b];
      sel_h = outsel_reg[2*b+1];
      hs_next[b] = dec_high(sel_h, sel_l, pwm_i);
      ls_next[b] = dec_low(sel_h, sel_l, pwm_i, recirc_reg);
      if (bridge_off[b])
      begin
        hs_next[b] = 1'b0;
        ls_next[b] = 1'b0;
      end
      if (!ls_gate_off_i[b] || ls_on_reg[b])
        hs_next[b] = 1'b0;
      if (!hs_gate_off_i[b] || hs_on_reg[b])
        ls_next[b] = 1'b0;
    end
  end

  // ==========================================================
  // Registered gate commands
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_on_reg <= {NUM_BRIDGES{1'b0}};
      ls_on_reg <= {NUM_BRIDGES{1'b0}};
    end
    else
    begin
      hs_on_reg <= hs_next;
      ls_on_reg <= ls_next;
    end
  end

  // Registered second-threshold hard kill and interrupt
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      kill_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end
    else
    begin
      kill_reg <= hard_kill;
      irq_reg  <= |(irq_flag_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // Read data mux, unmapped reads zero
  // Raw temperature and voltage fault inputs are readable so software can tell
  // whether a flag clear will hold or be set again at once
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_reg <= 32'h00000000;
    else if (rd_cyc)
    begin
      case (avs_address_i)
        `HBC_ADDR_OUTSEL:  rdata_reg <= {24'h000000, outsel_reg};
        `HBC_ADDR_STSCTL:  rdata_reg <= {24'h000000, ocf_reg, 3'h0, recirc_reg};
        `HBC_ADDR_SYSTEM_CONTROL_REG:  rdata_reg <= {28'h0000000, shdn_sel_reg, vis_reg, power_stage_enable_reg};
        `HBC_ADDR_IRQFLAG: rdata_reg <= {29'h0, irq_flag_reg};
        `HBC_ADDR_IRQMASK: rdata_reg <= {29'h0, irq_mask_reg};
        `HBC_ADDR_MUXCTL:  rdata_reg <= {24'h000000, mux_sel_reg, 3'h0, gain_reg};
        `HBC_ADDR_FAULTIN: rdata_reg <= {27'h0, second_temp_threshold_i,
                                         overvoltage_i, undervoltage_i,
                                         first_temp_threshold_i, pwm_i};
        default:           rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign avs_readdata_o      = rdata_reg;
  assign avs_waitrequest_o   = wait_reg;
  assign hs_on_o             = hs_on_reg;
  assign ls_on_o             = ls_on_reg;
  assign all_stages_off_o    = kill_reg;
  assign sense_gain_select_o = gain_reg;
  assign mux_select_o        = mux_sel_reg;
  assign irq_o               = irq_reg;

endmodule // hbc_bridge_ctrl

//--- verif/hbc_checker.sv
// ==========================================================
// Port-level checks on gate commands, faults and interrupt
module hbc_checker #(
  parameter NUM_BRIDGES = 4
) (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   avs_write_i,
  input wire logic [NUM_BRIDGES-1:0] hs_oc_i,
  input wire logic [NUM_BRIDGES-1:0] ls_oc_i,
  input wire logic [NUM_BRIDGES-1:0] hs_gate_off_i,
  input wire logic [NUM_BRIDGES-1:0] ls_gate_off_i,
  input wire logic                   second_temp_threshold_i,
  input wire logic [NUM_BRIDGES-1:0] hs_on_o,
  input wire logic [NUM_BRIDGES-1:0] ls_on_o,
  input wire logic                   all_stages_off_o,
  input wire logic                   sense_gain_select_o,
  input wire logic                   irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_no_shoot_through: assert property (!(|(hs_on_o & ls_on_o)))
    else $error("high and low switch on together");
  chk_oc_blank: assert property (!(|((hs_on_o | ls_on_o) & $past(hs_oc_i | ls_oc_i))))
    else $error("switch on after over-current");
  chk_hs_bbm: assert property (!(|(hs_on_o & ~$past(hs_on_o)
    & ~($past(ls_gate_off_i) & ~$past(ls_on_o))))) else $error("high side on too early");
  chk_ls_bbm: assert property (!(|(ls_on_o & ~$past(ls_on_o)
    & ~($past(hs_gate_off_i) & ~$past(hs_on_o))))) else $error("low side on too early");
  chk_kill_cause: assert property ($rose(all_stages_off_o) |->
    $past(second_temp_threshold_i) || $past(second_temp_threshold_i, 2)) else $error("bad kill");
  chk_kill_all_off: assert property (all_stages_off_o && $past(all_stages_off_o)
    |-> !(|{hs_on_o, ls_on_o})) else $error("stage on during kill");
  chk_irq_clear: assert property ($fell(irq_o) |->
    $past(avs_write_i) || $past(avs_write_i, 2)) else $error("irq dropped without write");
  chk_gain_hold: assert property ($changed(sense_gain_select_o) |->
    $past(avs_write_i) || $past(avs_write_i, 2)) else $error("gain changed without write");
endmodule // hbc_checker

bind hbc_bridge_ctrl hbc_checker #(.NUM_BRIDGES(NUM_BRIDGES)) u_chk (.core_clk_i, .rst_n_i,
  .avs_write_i, .hs_oc_i, .ls_oc_i, .hs_gate_off_i, .ls_gate_off_i, .second_temp_threshold_i,
  .hs_on_o, .ls_on_o, .all_stages_off_o, .sense_gain_select_o, .irq_o);

//--- verif/hbc_power_stage.sv
// ==========================================================
// Gate drivers: discharge takes one or two cycles
module hbc_power_stage (
  input  wire logic       core_clk_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] hs_on_i,
  input  wire logic [3:0] ls_on_i,
  output logic      [3:0] hs_gate_off_o,
  output logic      [3:0] ls_gate_off_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] off_d1;
  logic [7:0] off_d2;
  always @(posedge core_clk_i)
  begin
    off_d1 <= ~{hs_on_i, ls_on_i};
    off_d2 <= off_d1 & ~{hs_on_i, ls_on_i};
  end
  assign {hs_gate_off_o, ls_gate_off_o} = (slow_i ? off_d2 : off_d1) & ~{hs_on_i, ls_on_i};
endmodule // hbc_power_stage

//--- verif/hbc_bridge_ctrl_tb.sv
// ==========================================================
// Stimulus, reference model and comparisons
module hbc_bridge_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic        pwm_i = 1'b0, slow = 1'b0, first_temp_threshold_i = 1'b0;
  logic        second_temp_threshold_i = 1'b0, undervoltage_i = 1'b0, overvoltage_i = 1'b0;
  logic        avs_waitrequest_o, all_stages_off_o, sense_gain_select_o, irq_o;
  logic [3:0]  hs_oc_i = 4'h0, ls_oc_i = 4'h0, hs_gate_off_i, ls_gate_off_i;
  logic [3:0]  hs_on_o, ls_on_o, mux_select_o;
  logic [5:0]  avs_address_i = 6'h00;
  logic [5:0]  ra[7] = '{6'h04, 6'h0C, 6'h20, 6'h24, 6'h28, 6'h2C, 6'h3C};
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, lfsr = 32'h90A5;
  int          n_fail = 0, n_compared = 0, sel = 0, recirculation_mode = 0, power_stage_enable = 0;
  hbc_bridge_ctrl uut (.core_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .pwm_i, .hs_oc_i, .ls_oc_i,
    .hs_gate_off_i, .ls_gate_off_i, .first_temp_threshold_i, .second_temp_threshold_i,
    .undervoltage_i, .overvoltage_i, .hs_on_o, .ls_on_o, .all_stages_off_o,
    .sense_gain_select_o, .mux_select_o, .irq_o);
  hbc_power_stage u_stage (.core_clk_i, .slow_i(slow), .hs_on_i(hs_on_o), .ls_on_i(ls_on_o),
    .hs_gate_off_o(hs_gate_off_i), .ls_gate_off_o(ls_gate_off_i));
  // Clock, 100 ns period
  always #50 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // Expected gate commands from select, mode and blocked bridges
  function automatic logic [7:0] model(input logic [3:0] blk);
    logic [7:0] o;
    int c;
    for (int b = 0; b < 4; b++)
    begin
      c = (sel >> (2 * b)) & 3;
      o[b] = c == 1 || (c == 3 && recirculation_mode[0] && !pwm_i);
      o[4 + b] = c == 2 || (c == 3 && pwm_i);
    end
    return power_stage_enable != 0 ? o & ~{blk, blk} : 8'h00;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One register transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Write, let gates settle, compare outputs with the model
  task automatic wo(input logic [5:0] a, input logic [31:0] d, input logic [3:0] blk);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (6) @(posedge core_clk_i);
    chk({24'h0, hs_on_o, ls_on_o}, {24'h0, model(blk)});
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #2000000;
    n_fail++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    pwm_i <= 1'b1;
    foreach (ra[i]) rchk(ra[i], 32'h0);
    sel = 255;
    wo(6'h04, sel, 4'h0);
    power_stage_enable = 1;
    wo(6'h20, 32'h1, 4'h0);
    $display("test enable done");
    for (int k = 0; k < 24; k++)
    begin
      recirculation_mode = k / 2 % 2;
      pwm_i <= ^rnd();
      slow <= k[0];
      wo(6'h0C, recirculation_mode, 4'h0);
      sel = k < 4 ? k * 85 : rnd() & 255;
      wo(6'h04, sel, 4'h0);
    end
    $display("test decode done");
    sel = 8'h5A;
    wo(6'h04, sel, 4'h0);
    hs_oc_i <= 4'h1;
    ls_oc_i <= 4'h8;
    @(posedge core_clk_i);
    hs_oc_i <= 4'h0;
    ls_oc_i <= 4'h0;
    rchk(6'h0C, 32'h90 | recirculation_mode);
    wo(6'h0C, recirculation_mode, 4'h9);
    wo(6'h0C, 32'h90 | recirculation_mode, 4'h0);
    rchk(6'h0C, recirculation_mode);
    $display("test over-current done");
    wo(6'h28, 32'h1, 4'h0);
    first_temp_threshold_i <= 1'b1;
    wo(6'h20, 32'h5, 4'hF);
    chk({31'h0, irq_o}, 32'h1);
    wo(6'h24, 32'h1, 4'hF);
    first_temp_threshold_i <= 1'b0;
    wo(6'h24, 32'h1, 4'h0);
    chk({31'h0, irq_o}, 32'h0);
    wo(6'h28, 32'h0, 4'h0);
    first_temp_threshold_i <= 1'b1;
    wo(6'h20, 32'h1, 4'h0);
    chk({31'h0, irq_o}, 32'h0);
    first_temp_threshold_i <= 1'b0;
    second_temp_threshold_i <= 1'b1;
    wo(6'h2C, 32'h51, 4'hF);
    chk({26'h0, all_stages_off_o, sense_gain_select_o, mux_select_o}, 32'h35);
    second_temp_threshold_i <= 1'b0;
    wo(6'h24, 32'h1, 4'h0);
    wo(6'h2C, 32'hC0, 4'h0);
    chk({26'h0, all_stages_off_o, sense_gain_select_o, mux_select_o}, 32'h0C);
    $display("test temperature done");
    for (int v = 1; v < 3; v++)
    begin
      {overvoltage_i, undervoltage_i} <= 2'(v);
      wo(6'h20, 32'h3, 4'h0);
      wo(6'h20, 32'h1, 4'hF);
      wo(6'h24, 32'h1 << v, 4'hF);
      {overvoltage_i, undervoltage_i} <= 2'b00;
      wo(6'h24, 32'h1 << v, 4'h0);
      rchk(6'h24, 32'h0);
    end
    $display("test voltage done");
    print_verdict();
  end
endmodule // hbc_bridge_ctrl_tb
